// file: logic/run_ctrl_defs.svh
// Purpose: Constants for the counter run-control block
// Assumes: 200 MHz mclk
// Notes: Counts derived from printed times
`ifndef RUN_CTRL_DEFS_SVH
`define RUN_CTRL_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 5
`define MIN_PULSE_NS 100
`define MIN_PULSE_CYC ((`MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------
// Acquisition memory
// ----------------------------------------
`define ACQ_DEPTH 10000
`define ACQ_AW 14
`define CNT_W 32
`define TMR_W 40

// ----------------------------------------
// ASCII
// ----------------------------------------
`define CH_CR 8'h0d
`define CH_LF 8'h0a
`define CH_R 8'h52
`define CH_S 8'h53
`define CH_N 8'h4e
`define CH_T 8'h54
`define CH_C 8'h43
`define CH_O 8'h4f
`define CH_F 8'h46
`define CH_K 8'h4b
`define CH_G 8'h47
`define CH_US 8'h5f

// ----------------------------------------
// Reset values
// ----------------------------------------
`define POL_RESET 4'h0
`define REPLY_LEN 4'ha

`endif

// file: logic/run_ctrl_pkg.sv
// Purpose: Types for the counter run-control block
// Assumes: Nothing
// Notes: Commands decoded upstream from ASCII lines
package run_ctrl_pkg;

	typedef enum logic [2:0]
	{
		cmd_none,
		cmd_start,
		cmd_stop,
		cmd_enable_preset_channel_stop,
		cmd_enable_timer_stop,
		cmd_disable_auto_stop,
		cmd_query_run_mode,
		cmd_unknown
	} cmd_e;

	typedef enum logic [1:0]
	{
		stop_none,
		stop_counter,
		stop_timer
	} stop_mode_e;

endpackage

// file: logic/edge_if.sv
// Purpose: Carrier for synchronised start and stop rising edges and the gate level
// Assumes: Single clock mclk
// Notes: Driven by the input conditioner
`timescale 1ns/10ps
interface edge_if;
	logic start_rise;
	logic stop_rise;
	logic gate_level;

	modport src
	(
		output start_rise,
		output stop_rise,
		output gate_level
	);
	modport dst
	(
		input start_rise,
		input stop_rise,
		input gate_level
	);
endinterface

// file: logic/input_conditioner.sv
// Purpose: Synchronise start, stop and gate inputs; edge-detect start and stop
// Assumes: Inputs already polarity-corrected
// Notes: Second stage feeds edge logic
`timescale 1ns/10ps
module input_conditioner
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Raw levels
	input wire logic start_in,
	input wire logic stop_in,
	input wire logic gate_in,
	// Conditioned
	edge_if.src ev
);

	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] prev;

	// ----------------------------------------
	// Two-stage synchroniser and edge detect
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			sync1 <= 3'h4;
			sync2 <= 3'h4;
			prev <= 3'h4;
		end
		else
		begin
			sync1 <= {gate_in, stop_in, start_in};
			sync2 <= sync1;
			prev <= sync2;
		end
	end

	assign ev.start_rise = sync2[0] & ~prev[0];
	assign ev.stop_rise = sync2[1] & ~prev[1];
	assign ev.gate_level = sync2[2];

endmodule

// file: logic/counter_run_control.sv
// Purpose: Run control for an eight-channel counter with timer
// Assumes: Host commands decoded to single-cycle strobes upstream
// Notes: Mode reply is streamed out one ASCII byte per accept
//
// Function
// - Active start input begins counting on all channels until stop.
// - Active stop input ends the counting run.
// - Counting spans from start active until stop active.
// - Host start and stop commands also control the run.
// - Gate low suspends counting and keeps accumulated counts.
// - Gate returning high resumes counting without a new start.
// - Unconnected gate reads as high.
// - Gated acquisition stores counts while gate active, at most 10000 entries.
// - Run output high only while started and gate high.
// - Start, stop, gate and run polarity each invertible, default high.
// - Messages are ASCII ended by CR LF.
// - All-reply setting answers OK or NG to every command except the mode query.
// - Latest command from either port is acted on.
// - Counter-stop mode ends run when preset channel reaches preset.
// - Timer-stop mode ends run when timer reaches preset.
// - Timer-stop command ignored during gated acquisition.
// - Auto stop off: only stop command, input or acquisition end stop.
// - Mode query returns R, SN, stop mode T/C/N, state O/F.
// - Stop mode kept in non-volatile store and restored.
// - Power-up leaves counting off.
`timescale 1ns/10ps
`include "run_ctrl_defs.svh"
module counter_run_control
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// External pins
	input wire logic start_pin,
	input wire logic stop_pin,
	input wire logic gate_pin,
	output logic run_pin,
	// Configuration
	input wire logic [3:0] invert_pol,
	input wire logic all_reply,
	input wire logic acq_mode,
	// Commands from LAN and USB
	input wire logic lan_cmd_valid,
	input wire run_ctrl_pkg::cmd_e lan_cmd,
	input wire logic usb_cmd_valid,
	input wire run_ctrl_pkg::cmd_e usb_cmd,
	// Reply stream
	output logic reply_valid,
	output logic [7:0] reply_byte,
	output logic reply_last,
	input wire logic reply_ready,
	// Counts and presets
	input wire logic [`CNT_W-1:0] preset_count,
	input wire logic [`CNT_W-1:0] preset_chan_count,
	input wire logic [`TMR_W-1:0] preset_timer,
	input wire logic [`TMR_W-1:0] timer_value,
	// Non-volatile stop mode store
	input wire logic [1:0] nv_mode_in,
	input wire logic nv_mode_valid,
	output logic [1:0] nv_mode_out,
	output logic nv_mode_write,
	// Status
	output logic count_enable,
	output logic running,
	output logic acq_write,
	output logic [`ACQ_AW-1:0] acq_addr,
	output logic acq_full
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	edge_if ev();
	run_ctrl_pkg::stop_mode_e stop_mode;
	run_ctrl_pkg::cmd_e cur_cmd;
	logic run_state;
	logic next_run;
	logic [`CNT_W-1:0] acq_mem [0:`ACQ_DEPTH-1];
	logic [3:0] reply_idx;
	logic [3:0] reply_len;
	logic reply_busy;
	logic reply_ok;
	logic nv_loaded;

	// ----------------------------------------
	// Input polarity and conditioning
	// ----------------------------------------
	wire start_lvl = start_pin ^ invert_pol[0];
	wire stop_lvl = stop_pin ^ invert_pol[1];
	// Open gate pin is pulled high on the board
	wire gate_lvl = gate_pin ^ invert_pol[2];

	input_conditioner u_cond
	(
		.mclk(mclk),
		.srst(srst),
		.start_in(start_lvl),
		.stop_in(stop_lvl),
		.gate_in(gate_lvl),
		.ev(ev.src)
	);

	// ----------------------------------------
	// Command selection
	// ----------------------------------------
	// USB taken when both arrive together as the later one
	wire cmd_valid = lan_cmd_valid | usb_cmd_valid;
	assign cur_cmd = usb_cmd_valid ? usb_cmd : lan_cmd;
	wire accept = cmd_valid & ~reply_busy;
	wire is_start = accept & (cur_cmd == run_ctrl_pkg::cmd_start);
	wire is_stop = accept & (cur_cmd == run_ctrl_pkg::cmd_stop);
	wire is_cstop = accept & (cur_cmd == run_ctrl_pkg::cmd_enable_preset_channel_stop);
	wire is_tstop = accept & (cur_cmd == run_ctrl_pkg::cmd_enable_timer_stop) & ~acq_mode;
	wire is_nstop = accept & (cur_cmd == run_ctrl_pkg::cmd_disable_auto_stop);
	wire is_query = accept & (cur_cmd == run_ctrl_pkg::cmd_query_run_mode);
	wire is_bad = accept & ((cur_cmd == run_ctrl_pkg::cmd_unknown)
		| ((cur_cmd == run_ctrl_pkg::cmd_enable_timer_stop) & acq_mode));

	// ----------------------------------------
	// Stop conditions
	// ----------------------------------------
	wire cnt_hit = (stop_mode == run_ctrl_pkg::stop_counter)
		& (preset_chan_count >= preset_count);
	wire tmr_hit = (stop_mode == run_ctrl_pkg::stop_timer)
		& (timer_value >= preset_timer);
	wire acq_end = acq_mode & acq_full;
	wire any_stop = ev.stop_rise | is_stop | cnt_hit | tmr_hit | acq_end;
	wire any_start = ev.start_rise | is_start;

	// ----------------------------------------
	// Run state
	// ----------------------------------------
	always_comb
	begin
		next_run = run_state;
		if (any_stop)
			next_run = 1'b0;
		else if (any_start)
			next_run = 1'b1;
	end

	// Gate suspends counting only, run stays armed
	wire valid_count = next_run & ev.gate_level;

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			run_state <= 1'b0;
			count_enable <= 1'b0;
			running <= 1'b0;
			run_pin <= 1'b0;
		end
		else
		begin
			run_state <= next_run;
			count_enable <= valid_count;
			running <= next_run;
			run_pin <= valid_count ^ invert_pol[3];
		end
	end

	// ----------------------------------------
	// Stop mode with non-volatile restore
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			stop_mode <= run_ctrl_pkg::stop_none;
			nv_loaded <= 1'b0;
			nv_mode_out <= 2'h0;
			nv_mode_write <= 1'b0;
		end
		else
		begin
			nv_mode_write <= 1'b0;
			if (!nv_loaded && nv_mode_valid)
			begin
				stop_mode <= run_ctrl_pkg::stop_mode_e'(nv_mode_in);
				nv_loaded <= 1'b1;
			end
			else if (is_cstop | is_tstop | is_nstop)
			begin
				stop_mode <= is_cstop ? run_ctrl_pkg::stop_counter
					: (is_tstop ? run_ctrl_pkg::stop_timer : run_ctrl_pkg::stop_none);
				nv_mode_out <= is_cstop ? 2'h1 : (is_tstop ? 2'h2 : 2'h0);
				nv_mode_write <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Gated acquisition memory
	// ----------------------------------------
	wire acq_store = acq_mode & run_state & ev.gate_level & ~acq_full;

	always_ff @(posedge mclk)
	begin
		if (acq_store)
			acq_mem[acq_addr] <= preset_chan_count;
	end

	always_ff @(posedge mclk)
	begin
		if (srst || any_start)
		begin
			acq_addr <= '0;
			acq_full <= 1'b0;
			acq_write <= 1'b0;
		end
		else
		begin
			acq_write <= acq_store;
			if (acq_store)
			begin
				if (acq_addr == `ACQ_AW'(`ACQ_DEPTH - 1))
					acq_full <= 1'b1;
				else
					acq_addr <= acq_addr + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Reply stream
	// ----------------------------------------
	wire [7:0] mode_chr = (stop_mode == run_ctrl_pkg::stop_timer) ? `CH_T
		: ((stop_mode == run_ctrl_pkg::stop_counter) ? `CH_C : `CH_N);
	wire [7:0] state_chr = run_state ? `CH_O : `CH_F;
	wire need_reply = is_query | is_bad | (all_reply & accept);

	logic [7:0] sel_chr;
	always_comb
	begin
		sel_chr = `CH_LF;
		if (reply_len == `REPLY_LEN)
		begin
			case (reply_idx)
				4'h0: sel_chr = `CH_R;
				4'h1: sel_chr = `CH_US;
				4'h2: sel_chr = `CH_S;
				4'h3: sel_chr = `CH_N;
				4'h4: sel_chr = `CH_US;
				4'h5: sel_chr = mode_chr;
				4'h6: sel_chr = `CH_US;
				4'h7: sel_chr = state_chr;
				4'h8: sel_chr = `CH_CR;
				default: sel_chr = `CH_LF;
			endcase
		end
		else
		begin
			case (reply_idx)
				4'h0: sel_chr = reply_ok ? `CH_O : `CH_N;
				4'h1: sel_chr = reply_ok ? `CH_K : `CH_G;
				4'h2: sel_chr = `CH_CR;
				default: sel_chr = `CH_LF;
			endcase
		end
	end

	wire reply_step = reply_busy & (~reply_valid | reply_ready);

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			reply_busy <= 1'b0;
			reply_idx <= 4'h0;
			reply_len <= 4'h0;
			reply_ok <= 1'b0;
			reply_valid <= 1'b0;
			reply_byte <= 8'h00;
			reply_last <= 1'b0;
		end
		else if (need_reply)
		begin
			reply_busy <= 1'b1;
			reply_idx <= 4'h0;
			reply_len <= is_query ? `REPLY_LEN : 4'h4;
			reply_ok <= ~is_bad;
			reply_valid <= 1'b0;
		end
		else if (reply_step)
		begin
			reply_valid <= 1'b1;
			reply_byte <= sel_chr;
			reply_last <= (reply_idx == reply_len - 4'h1);
			reply_idx <= reply_idx + 4'h1;
			if (reply_idx == reply_len - 4'h1)
				reply_busy <= 1'b0;
		end
		else if (reply_valid && reply_ready)
		begin
			reply_valid <= 1'b0;
			reply_last <= 1'b0;
		end
	end

endmodule

// file: bench/run_ctrl_chk.sv
// Purpose: Port assertions for run control
// Assumes: Bound to counter_run_control
// Notes: Pin paths take three edges
`timescale 1ns/10ps
`include "run_ctrl_defs.svh"
module run_ctrl_chk
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Watched ports
	input wire logic start_pin,
	input wire logic stop_pin,
	input wire logic gate_pin,
	input wire logic run_pin,
	input wire logic [3:0] invert_pol,
	input wire logic lan_cmd_valid,
	input wire run_ctrl_pkg::cmd_e lan_cmd,
	input wire logic usb_cmd_valid,
	input wire run_ctrl_pkg::cmd_e usb_cmd,
	input wire logic reply_valid,
	input wire logic [7:0] reply_byte,
	input wire logic reply_last,
	input wire logic [`CNT_W-1:0] preset_count,
	input wire logic [`CNT_W-1:0] preset_chan_count,
	input wire logic [`TMR_W-1:0] preset_timer,
	input wire logic [`TMR_W-1:0] timer_value,
	input wire logic [1:0] nv_mode_out,
	input wire logic count_enable,
	input wire logic running,
	input wire logic acq_full
);
	// ----
	// Checks
	// ----
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);
	AST_PIN_START: assert property ($rose(start_pin) && !invert_pol[0] |-> ##3 running)
		else $error("start pin ignored");
	AST_PIN_STOP: assert property ($rose(stop_pin) && !invert_pol[1] |-> ##3 !running)
		else $error("stop pin ignored");
	AST_GATE_LOW: assert property ($fell(gate_pin) && running && !invert_pol[2]
		|-> ##3 !count_enable && running) else $error("gate low kept counting");
	AST_GATE_HIGH: assert property ($rose(gate_pin) && running && !invert_pol[2]
		|-> ##3 count_enable) else $error("gate high did not resume");
	AST_EN_RUN: assert property (count_enable |-> running)
		else $error("counting outside run");
	AST_RUN_IDLE: assert property (!running && !$past(running) && !$past(srst)
		&& $stable(invert_pol) |-> run_pin == invert_pol[3]) else $error("run pin idle level");
	AST_CMD_START: assert property (lan_cmd_valid && lan_cmd == run_ctrl_pkg::cmd_start
		&& !usb_cmd_valid && !reply_valid |=> running) else $error("start command ignored");
	AST_CMD_STOP: assert property (usb_cmd_valid && usb_cmd == run_ctrl_pkg::cmd_stop
		&& !reply_valid |=> !running) else $error("stop command ignored");
	AST_REPLY_END: assert property (reply_valid && reply_byte == 8'h0a |-> reply_last)
		else $error("line feed not last");
	AST_AUTO_CNT: assert property (running && nv_mode_out == 2'h1
		&& preset_chan_count >= preset_count |=> !running) else $error("counter stop missed");
	AST_AUTO_TMR: assert property (running && nv_mode_out == 2'h2
		&& timer_value >= preset_timer |=> !running) else $error("timer stop missed");
	CVR_RUN: cover property ($rose(running));
	CVR_GATE: cover property (running && $fell(count_enable));
	CVR_FULL: cover property (acq_full ##1 !running);
endmodule

// file: bench/host_model.sv
// Purpose: Host model issuing decoded commands
// Assumes: One command in flight
// Notes: Receiver stalls at random
`timescale 1ns/10ps
module host_model
(
	// Clock
	input wire logic mclk,
	// Commands
	output logic lan_cmd_valid,
	output run_ctrl_pkg::cmd_e lan_cmd,
	output logic usb_cmd_valid,
	output run_ctrl_pkg::cmd_e usb_cmd,
	// Replies
	input wire logic reply_valid,
	input wire logic reply_last,
	output logic reply_ready
);
	initial
	begin
		lan_cmd_valid = 1'b0;
		usb_cmd_valid = 1'b0;
		lan_cmd = run_ctrl_pkg::cmd_none;
		usb_cmd = run_ctrl_pkg::cmd_none;
		reply_ready = 1'b0;
	end
	always @(posedge mclk)
		reply_ready <= ($urandom % 3) != 0;
	task automatic send(input logic lv, input run_ctrl_pkg::cmd_e lc, input logic uv,
		input run_ctrl_pkg::cmd_e uc, input logic wr);
		int n;
		n = 0;
		lan_cmd_valid <= lv;
		lan_cmd <= lc;
		usb_cmd_valid <= uv;
		usb_cmd <= uc;
		@(posedge mclk);
		lan_cmd_valid <= 1'b0;
		usb_cmd_valid <= 1'b0;
		lan_cmd <= run_ctrl_pkg::cmd_e'(~lc);
		usb_cmd <= run_ctrl_pkg::cmd_e'(~uc);
		while (wr && !(reply_valid && reply_ready && reply_last) && n < 300)
		begin
			@(posedge mclk);
			n++;
		end
		repeat (2) @(posedge mclk);
	endtask
endmodule

// file: bench/tb.sv
// Purpose: Self-checking bench for run control
// Assumes: Host model drives commands
// Notes: Reply bytes checked from a queue
`timescale 1ns/10ps
`include "run_ctrl_defs.svh"
`define CHK(nm, ex, got) \
	begin \
		cmp_count++; \
		if ((got) !== (ex)) \
		begin \
			fail_count++; \
			$display("BAD %s exp %0h got %0h", nm, ex, got); \
		end \
	end
module tb;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic [2:0] pins = 3'h4;
	logic [3:0] invert_pol = 4'h0;
	logic all_reply = 1'b0;
	logic acq_mode = 1'b0;
	logic [`CNT_W-1:0] preset_count = '1;
	logic [`CNT_W-1:0] preset_chan_count = '0;
	logic [`TMR_W-1:0] preset_timer = '1;
	logic [`TMR_W-1:0] timer_value = '0;
	logic [1:0] nv_mode_in = 2'h0;
	logic nv_mode_valid = 1'b0;
	logic lan_cmd_valid, usb_cmd_valid, reply_ready, run_pin, reply_valid, reply_last;
	run_ctrl_pkg::cmd_e lan_cmd, usb_cmd;
	logic [7:0] reply_byte, exp_b;
	logic [1:0] nv_mode_out;
	logic nv_mode_write, count_enable, running, acq_write, acq_full;
	logic [`ACQ_AW-1:0] acq_addr;
	logic [7:0] exp_q[$];
	int fail_count = 0;
	int cmp_count = 0;
	int n_wr = 0;
	counter_run_control dut
	(
		.mclk, .srst, .start_pin(pins[0]), .stop_pin(pins[1]), .gate_pin(pins[2]), .run_pin,
		.invert_pol, .all_reply, .acq_mode, .lan_cmd_valid, .lan_cmd, .usb_cmd_valid, .usb_cmd,
		.reply_valid, .reply_byte, .reply_last, .reply_ready, .preset_count, .preset_chan_count,
		.preset_timer, .timer_value, .nv_mode_in, .nv_mode_valid, .nv_mode_out, .nv_mode_write,
		.count_enable, .running, .acq_write, .acq_addr, .acq_full
	);
	host_model host
	(
		.mclk, .lan_cmd_valid, .lan_cmd, .usb_cmd_valid, .usb_cmd, .reply_valid, .reply_last,
		.reply_ready
	);
	always #2.5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		if (acq_write)
			n_wr++;
		if (reply_valid && reply_ready)
		begin
			exp_b = exp_q.size() ? exp_q.pop_front() : 8'hxx;
			`CHK("reply", exp_b, reply_byte)
		end
	end
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cmd(input run_ctrl_pkg::cmd_e c, input string ex, input logic uv = 1'b0,
		input run_ctrl_pkg::cmd_e uc = run_ctrl_pkg::cmd_none);
		foreach (ex[i])
			exp_q.push_back(ex[i]);
		if (ex.len() > 0)
		begin
			exp_q.push_back(8'h0d);
			exp_q.push_back(8'h0a);
		end
		host.send(1'b1, c, uv, uc, ex.len() > 0);
	endtask
	task automatic flip(input int b);
		pins[b] <= ~pins[b];
		repeat (24) @(posedge mclk);
	endtask
	task automatic chk3(input logic r, input logic e, input logic p);
		repeat (4) @(posedge mclk);
		`CHK("running", r, running)
		`CHK("count_enable", e, count_enable)
		`CHK("run_pin", p, run_pin)
	endtask
	initial
	begin
		#150000;
		fail_count++;
		end_of_test();
	end
	initial
	begin
		void'($urandom(87));
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		repeat (2) @(posedge mclk);
		nv_mode_in <= 2'h2;
		nv_mode_valid <= 1'b1;
		@(posedge mclk);
		nv_mode_valid <= 1'b0;
		chk3(1'b0, 1'b0, 1'b0);
		cmd(run_ctrl_pkg::cmd_query_run_mode, "R_SN_T_F");
		cmd(run_ctrl_pkg::cmd_disable_auto_stop, "");
		flip(0);
		flip(0);
		chk3(1'b1, 1'b1, 1'b1);
		cmd(run_ctrl_pkg::cmd_query_run_mode, "R_SN_N_O");
		flip(2);
		chk3(1'b1, 1'b0, 1'b0);
		flip(2);
		chk3(1'b1, 1'b1, 1'b1);
		flip(1);
		flip(1);
		chk3(1'b0, 1'b0, 1'b0);
		all_reply <= 1'b1;
		cmd(run_ctrl_pkg::cmd_start, "OK");
		chk3(1'b1, 1'b1, 1'b1);
		cmd(run_ctrl_pkg::cmd_start, "OK", 1'b1, run_ctrl_pkg::cmd_stop);
		chk3(1'b0, 1'b0, 1'b0);
		cmd(run_ctrl_pkg::cmd_enable_preset_channel_stop, "OK");
		preset_count <= $urandom | 32'h1;
		cmd(run_ctrl_pkg::cmd_start, "OK");
		preset_chan_count <= preset_count - 32'h1;
		chk3(1'b1, 1'b1, 1'b1);
		preset_chan_count <= preset_count;
		chk3(1'b0, 1'b0, 1'b0);
		acq_mode <= 1'b1;
		cmd(run_ctrl_pkg::cmd_enable_timer_stop, "NG");
		cmd(run_ctrl_pkg::cmd_query_run_mode, "R_SN_C_F");
		acq_mode <= 1'b0;
		cmd(run_ctrl_pkg::cmd_unknown, "NG");
		cmd(run_ctrl_pkg::cmd_enable_timer_stop, "OK");
		preset_timer <= {8'h00, $urandom} | 40'h1;
		preset_chan_count <= 32'h0;
		cmd(run_ctrl_pkg::cmd_start, "OK");
		timer_value <= preset_timer - 40'h1;
		chk3(1'b1, 1'b1, 1'b1);
		timer_value <= preset_timer;
		chk3(1'b0, 1'b0, 1'b0);
		cmd(run_ctrl_pkg::cmd_disable_auto_stop, "OK");
		cmd(run_ctrl_pkg::cmd_start, "OK");
		chk3(1'b1, 1'b1, 1'b1);
		cmd(run_ctrl_pkg::cmd_stop, "OK");
		acq_mode <= 1'b1;
		n_wr = 0;
		cmd(run_ctrl_pkg::cmd_start, "OK");
		for (int i = 0; i < 10100 && acq_full !== 1'b1; i++)
			@(posedge mclk);
		chk3(1'b0, 1'b0, 1'b0);
		`CHK("stored", 10000, n_wr)
		acq_mode <= 1'b0;
		invert_pol <= 4'h9;
		chk3(1'b1, 1'b1, 1'b0);
		cmd(run_ctrl_pkg::cmd_stop, "OK");
		`CHK("replies left", 0, exp_q.size())
		end_of_test();
	end
endmodule
bind counter_run_control run_ctrl_chk chk (.*);
